// ### inc/mcf_pkg.sv
// shared constants and carrier types for the motion command frame handler
package mcf_pkg;
	localparam int FRAME_BYTES = 9;
	localparam int BODY_BYTES = 7;
	localparam int CAN_REPLY_BYTES = 7;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_LOADED = 8'h65;
	localparam logic [7:0] ST_BAD_SUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;
	localparam logic [7:0] ST_LOCKED = 8'h05;
	localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
	localparam logic [7:0] ADDR_RESET = 8'h01;
	localparam logic [7:0] REPLY_ADDR_RESET = 8'h02;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] kind;
		logic [7:0] bank;
		logic [31:0] value;
	} mcf_cmd_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] opcode;
		logic [31:0] value;
	} mcf_reply_t;

	typedef enum logic [2:0] {
		S_RECV = 3'h0,
		S_EXEC = 3'h1,
		S_WAIT = 3'h2,
		S_SEND = 3'h3,
		S_DRAIN = 3'h4
	} mcf_state_t;
endpackage

// ### hdl/mcf_fifo.sv
// small synchronous fifo with valid/ready on both sides
module mcf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstSyncN,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic doWr;
	logic doRd;

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	assign outData = mem[rdPtr_q];

	always_ff @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doWr) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (doRd) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			if (doWr && !doRd) begin
				count_q <= count_q + 1'b1;
			end else if (doRd && !doWr) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // mcf_fifo

// ### hdl/mcf_checksum.sv
// running modulo-256 byte accumulator
module mcf_checksum (
	input wire logic clk,
	input wire logic rstSyncN,
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] dataIn,
	output logic [7:0] sum
);
	logic [7:0] sum_q;

	assign sum = sum_q;

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sum_q <= '0;
		end else if (clear) begin
			sum_q <= add ? dataIn : 8'h00;
		end else if (add) begin
			sum_q <= sum_q + dataIn;
		end
	end
endmodule // mcf_checksum

// ### hdl/mcf_frame_handler.sv
// command frame receive, execution handoff and reply transmit
//
// Contract
// - replies are only ever sent in answer to a frame that was received.
// - the reply is sent only after the execution stage reports the command done; a checksum error reply is sent without execution.
// - the link driver enable is high only while a reply is being sent.
// - the command body is opcode, type, bank and a four-byte value.
// - serial frames are address, seven body bytes and a checksum, nine bytes.
// - value bytes travel most significant byte first in both directions.
// - the received checksum must equal the 8-bit sum of the eight bytes before it.
// - in CAN mode frames carry only the seven body bytes with no address or checksum.
// - serial replies are reply address, module address, status, opcode, value, checksum.
// - the reply checksum is the 8-bit sum of all other reply bytes.
// - CAN replies drop address and checksum bytes and leave addressing to the identifier.
// - a command executed without error replies with status 100.
// - a command stored to program memory replies with status 101.
// - error statuses are 1 checksum, 2 command, 3 type, 4 value, 5 locked, 6 unavailable.
module mcf_frame_handler
	import mcf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic canMode,
	input wire logic [7:0] moduleAddr,
	input wire logic [7:0] replyAddr,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	output logic txEnable,
	output mcf_cmd_t cmd,
	output logic cmdValid,
	input wire logic cmdReady,
	input wire logic [7:0] execStatus,
	input wire logic [31:0] execValue,
	input wire logic execDone
);
	logic rstMeta_q;
	logic rstSync_q;
	mcf_state_t state_q;
	logic [3:0] rxCount_q;
	logic [3:0] txCount_q;
	logic [7:0] frameAddr_q;
	mcf_cmd_t cmd_q;
	mcf_reply_t reply_q;
	logic cmdValid_q;
	logic rxTake;
	logic lastRxByte;
	logic [7:0] rxSum;
	logic [7:0] txSum;
	logic [7:0] txByte;
	logic fifoInReady;
	logic fifoInValid;
	logic txTake;
	logic [3:0] txLast;
	logic [3:0] rxLast;
	logic [3:0] bodyIdx;
	logic sumOk;
	logic addrOk;
	logic txEmpty;
	logic fifoOutValid;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// receive only while idle so a new frame cannot overrun one in flight
	assign rxReady = (state_q == S_RECV);
	assign rxTake = rxValid && rxReady;
	assign rxLast = canMode ? 4'(BODY_BYTES - 1) : 4'(FRAME_BYTES - 1);
	assign lastRxByte = (rxCount_q == rxLast);
	// serial frames shift the body one position behind the address byte
	assign bodyIdx = canMode ? rxCount_q : rxCount_q - 4'h1;
	assign sumOk = (rxSum == rxData);
	assign addrOk = (frameAddr_q == moduleAddr);

	mcf_checksum u_rxSum (
		.clk(core_clk),
		.rstSyncN(rstSync_q),
		.clear(rxCount_q == 4'h0),
		.add(rxTake && !lastRxByte),
		.dataIn(rxData),
		.sum(rxSum)
	);

	always_ff @(posedge core_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			rxCount_q <= '0;
			frameAddr_q <= '0;
			cmd_q <= '0;
		end else if (rxTake) begin
			rxCount_q <= lastRxByte ? 4'h0 : rxCount_q + 4'h1;
			if (!canMode && rxCount_q == 4'h0) begin
				frameAddr_q <= rxData;
			end
			if (!(lastRxByte && !canMode) && !(rxCount_q == 4'h0 && !canMode)) begin
				case (bodyIdx)
					4'h0: cmd_q.opcode <= rxData;
					4'h1: cmd_q.kind <= rxData;
					4'h2: cmd_q.bank <= rxData;
					default: cmd_q.value <= {cmd_q.value[23:0], rxData};
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q <= S_RECV;
			cmdValid_q <= 1'b0;
			reply_q <= '0;
		end else begin
			case (state_q)
				S_RECV: begin
					if (rxTake && lastRxByte) begin
						if (canMode) begin
							state_q <= S_EXEC;
							cmdValid_q <= 1'b1;
						end else if (!addrOk) begin
							state_q <= S_RECV;
						end else if (!sumOk) begin
							reply_q <= '{status: ST_BAD_SUM, opcode: cmd_q.opcode, value: 32'h0000_0000};
							state_q <= S_SEND;
						end else begin
							state_q <= S_EXEC;
							cmdValid_q <= 1'b1;
						end
					end
				end
				S_EXEC: begin
					if (cmdReady) begin
						cmdValid_q <= 1'b0;
						state_q <= S_WAIT;
					end
				end
				S_WAIT: begin
					// execution stage supplies 100, 101 or an error code
					if (execDone) begin
						reply_q <= '{status: execStatus, opcode: cmd_q.opcode, value: execValue};
						state_q <= S_SEND;
					end
				end
				S_SEND: begin
					if (txTake && txCount_q == txLast) begin
						state_q <= S_DRAIN;
					end
				end
				S_DRAIN: begin
					if (txEmpty) begin
						state_q <= S_RECV;
					end
				end
				default: state_q <= S_RECV;
			endcase
		end
	end

	assign cmd = cmd_q;
	assign cmdValid = cmdValid_q;

	// reply bytes are generated only in S_SEND, entered only after a received frame
	assign fifoInValid = (state_q == S_SEND);
	assign txTake = fifoInValid && fifoInReady;
	assign txLast = canMode ? 4'(CAN_REPLY_BYTES - 1) : 4'(FRAME_BYTES - 1);

	always_comb begin
		txByte = 8'h00;
		if (canMode) begin
			case (txCount_q)
				4'h0: txByte = reply_q.status;
				4'h1: txByte = reply_q.opcode;
				4'h2: txByte = reply_q.value[31:24];
				4'h3: txByte = reply_q.value[23:16];
				4'h4: txByte = reply_q.value[15:8];
				4'h5: txByte = reply_q.value[7:0];
				default: txByte = 8'h00;
			endcase
		end else begin
			case (txCount_q)
				4'h0: txByte = replyAddr;
				4'h1: txByte = moduleAddr;
				4'h2: txByte = reply_q.status;
				4'h3: txByte = reply_q.opcode;
				4'h4: txByte = reply_q.value[31:24];
				4'h5: txByte = reply_q.value[23:16];
				4'h6: txByte = reply_q.value[15:8];
				4'h7: txByte = reply_q.value[7:0];
				default: txByte = txSum;
			endcase
		end
	end

	mcf_checksum u_txSum (
		.clk(core_clk),
		.rstSyncN(rstSync_q),
		.clear(txCount_q == 4'h0),
		.add(txTake),
		.dataIn(txByte),
		.sum(txSum)
	);

	always_ff @(posedge core_clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			txCount_q <= '0;
		end else if (txTake) begin
			txCount_q <= (txCount_q == txLast) ? 4'h0 : txCount_q + 4'h1;
		end
	end

	mcf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_txFifo (
		.clk(core_clk),
		.rstSyncN(rstSync_q),
		.inData(txByte),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.outData(txData),
		.outValid(fifoOutValid),
		.outReady(txReady)
	);

	assign txValid = fifoOutValid;
	assign txEmpty = !fifoOutValid;
	// bus stays released unless a reply is in flight
	assign txEnable = (state_q == S_SEND) || (state_q == S_DRAIN);
endmodule // mcf_frame_handler

// ### test/mcf_frame_handler_monitor.sv
// port checker for the frame handler, bound to every instance
module mcf_monitor
	import mcf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic canMode,
	input wire logic [7:0] replyAddr,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic txEnable,
	input wire mcf_cmd_t cmd,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic execDone
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	tx_enable_a: assert property (txValid |-> txEnable)
		else $error("tx without enable");
	rx_closed_a: assert property (txEnable |-> !rxReady)
		else $error("rx open while sending");
	cmd_hold_a: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmd))
		else $error("command changed");
	early_reply_a: assert property (cmdValid |-> !txEnable && !rxReady)
		else $error("reply before execution");
	done_reply_a: assert property (execDone && !rxReady && !cmdValid && !txEnable |=> txEnable)
		else $error("no reply after done");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("tx byte dropped");
	reply_head_a: assert property ($rose(txValid) && !canMode |-> txData == replyAddr)
		else $error("bad reply head");
	// enable drops one idle cycle after the last byte has left the fifo
	bus_release_a: assert property ($fell(txEnable) |-> $past(txValid, 2) && $past(txReady, 2) && !$past(txValid) && !txValid)
		else $error("bus held after reply");

	cover property (cmdValid && cmdReady);
	cover property ($rose(txValid) && canMode);
	cover property (txValid && !txReady);
endmodule // mcf_monitor

bind mcf_frame_handler mcf_monitor chk (.core_clk(core_clk), .rstn(rstn), .canMode(canMode),
	.replyAddr(replyAddr), .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
	.txEnable(txEnable), .cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady), .execDone(execDone));

// ### test/mcf_host.sv
// host model: sends command frames, collects reply bytes
module mcf_host (
	input wire logic clk,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic [7:0] rxData,
	output logic rxValid,
	output logic txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic slow = 1'b0;
	logic [7:0] got[$];
	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b1;
	end
	// a slow host drops txReady on every other cycle
	always @(negedge clk) txReady <= slow ? ~txReady : 1'b1;
	always @(posedge clk) if (txValid && txReady) got.push_back(txData);
	// late flags a byte that the block never accepted
	task automatic send(input logic [7:0] f[9], input int n, output bit late);
		int w;
		late = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			rxValid = 1'b1;
			rxData = f[i];
			w = 0;
			do @(posedge clk); while (!rxReady && ++w < 64);
			if (w >= 64) late = 1'b1;
		end
		@(negedge clk);
		rxValid = 1'b0;
		// idle line must not keep showing the last byte
		rxData = ~rxData;
	endtask
endmodule // mcf_host

// ### test/mcf_frame_handler_bench.sv
// self-checking bench for the frame handler
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mcf_frame_handler_bench
	import mcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rstn = 1'b0, canMode = 1'b0, cmdReady = 1'b0, execDone = 1'b0;
	logic [7:0] moduleAddr = 8'h05, replyAddr = 8'h02, execStatus = 8'h00, rxData, txData;
	logic [31:0] execValue = 32'h0;
	logic rxValid, rxReady, txValid, txReady, txEnable, cmdValid;
	mcf_cmd_t cmd;
	int error_cnt = 0, check_count = 0;
	always #4 core_clk = ~core_clk;
	mcf_frame_handler dut (.core_clk(core_clk), .rstn(rstn), .canMode(canMode), .moduleAddr(moduleAddr),
		.replyAddr(replyAddr), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txData(txData),
		.txValid(txValid), .txReady(txReady), .txEnable(txEnable), .cmd(cmd), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .execStatus(execStatus), .execValue(execValue), .execDone(execDone));
	mcf_host host (.clk(core_clk), .rxReady(rxReady), .txData(txData), .txValid(txValid),
		.rxData(rxData), .rxValid(rxValid), .txReady(txReady));

	task stop_test;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task fail_wait;
		error_cnt++;
		$display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
		stop_test;
	endtask

	// one command and its reply; bad corrupts the checksum, hit clear means foreign address
	task automatic xfer(input logic can, input logic [7:0] adr, op, input logic [31:0] v,
		input logic [7:0] bad, st, input bit hit);
		logic [7:0] f[9], e[9], s;
		logic [31:0] rv;
		int n, w;
		bit late;
		rv = ~v;
		s = (bad != 8'h00) ? ST_BAD_SUM : st;
		f = '{adr, op, 8'h03, 8'h01, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		for (int i = 0; i < 8; i++) f[8] += f[i];
		f[8] += bad;
		n = can ? 7 : 9;
		if (can) for (int i = 0; i < 7; i++) f[i] = f[i + 1];
		@(negedge core_clk);
		canMode = can;
		host.got.delete();
		host.send(f, n, late);
		if (late) fail_wait;
		if (!hit) begin
			repeat (30) @(negedge core_clk);
			`CHK(host.got.size(), 0)
			`CHK(rxReady, 1'b1)
			`CHK(cmdValid, 1'b0)
			return;
		end
		if (bad == 8'h00) begin
			w = 0;
			while (cmdValid !== 1'b1) begin @(negedge core_clk); if (++w > 64) fail_wait; end
			`CHK(cmd, {op, 8'h03, 8'h01, v})
			cmdReady = 1'b1;
			@(negedge core_clk);
			cmdReady = 1'b0;
			repeat (3) @(negedge core_clk);
			`CHK(txEnable, 1'b0)
			execStatus = st;
			execValue = rv;
			execDone = 1'b1;
			@(negedge core_clk);
			execDone = 1'b0;
		end else rv = 32'h0;
		e = '{replyAddr, moduleAddr, s, op, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
		for (int i = 0; i < 8; i++) e[8] += e[i];
		// reply pad byte stays zero in CAN framing
		if (can) for (int i = 0; i < 9; i++) e[i] = (i < 6) ? e[i + 2] : 8'h00;
		w = 0;
		while (txEnable !== 1'b0 || host.got.size() < n) begin @(negedge core_clk); if (++w > 300) fail_wait; end
		`CHK(host.got.size(), n)
		for (int i = 0; i < n; i++) `CHK(host.got[i], e[i])
		`CHK(cmdValid, 1'b0)
		`CHK(rxReady, 1'b1)
	endtask

	task t_serial_ok;
		xfer(1'b0, 8'h05, 8'h04, 32'h1234_5678, 8'h00, ST_OK, 1'b1);
	endtask
	task t_stored_slow;
		host.slow = 1'b1;
		xfer(1'b0, 8'h05, 8'h0A, 32'hFF00_00FF, 8'h00, ST_LOADED, 1'b1);
		host.slow = 1'b0;
	endtask
	task t_bad_sum;
		xfer(1'b0, 8'h05, 8'h06, 32'h0000_0001, 8'h01, 8'h00, 1'b1);
	endtask
	task t_foreign;
		xfer(1'b0, 8'h06, 8'h04, 32'h0000_0002, 8'h00, ST_OK, 1'b0);
	endtask
	task t_can;
		xfer(1'b1, 8'h00, 8'h05, 32'h8000_0001, 8'h00, ST_OK, 1'b1);
	endtask
	task t_errors;
		for (logic [7:0] c = ST_BAD_CMD; c <= ST_NOT_AVAIL; c++) xfer(1'b0, 8'h05, 8'h09, {24'h0, c}, 8'h00, c, 1'b1);
	endtask

	initial begin
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		repeat (3) @(negedge core_clk);
		t_serial_ok;
		t_stored_slow;
		t_bad_sum;
		t_foreign;
		t_can;
		t_errors;
		stop_test;
	end
endmodule // mcf_frame_handler_bench
